//--- hw/uvp_pkg.sv
// Overview of operation
// - Program mode: 25V supply, gate high, data driven.
// - High pulse, 50 ms nominal, 55 ms max.
// - Separate program pulse for every written location.
// - Program pulse is one steady level.
// - Verify at 25V with select and gate low.
// - Supply at 5V outside program and verify.
// - Reference select input held at fixed level.
// - Decode select per device; gate shared read strobe.
// - Identical data: pulse all devices together.
// - Different data: pulse target, hold others low.
package uvp_pkg;
   // Widths of the pin groups
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NDEV   = 4;
   localparam int DEV_W  = 2;
   localparam int CNT_W  = 21;
   // Clock and timing figures in their own units
   localparam int CLK_NS       = 50;
   localparam int ACC_NS       = 450;
   localparam int FLOAT_NS     = 100;
   localparam int SETUP_NS     = 2000;
   localparam int VPP_NS       = 2000;
   localparam int PULSE_MS     = 50;
   localparam int PULSE_MAX_MS = 55;
   localparam int NS_PER_MS    = 1000000;
   // Least times round up to whole cycles
   localparam int ACC_CYC   = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int VPP_CYC   = (VPP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = PULSE_MS * NS_PER_MS / CLK_NS;
   localparam int PULSE_MAX_CYC = PULSE_MAX_MS * NS_PER_MS / CLK_NS;
   // Reference select level for the standard part
   localparam logic REF_LEVEL = 1'b0;
   // Erased contents
   localparam logic [DATA_W-1:0] ERASED = 8'hff;

   typedef enum logic {OP_READ, OP_PROG} uvp_op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_RD_ACC, S_RD_FLOAT, S_PG_VPP, S_PG_SETUP, S_PG_PULSE,
      S_PG_HOLD, S_PV_ACC, S_PV_FLOAT, S_PG_VPPOFF
   } uvp_state_t;

   typedef struct packed {
      uvp_op_t             op;
      logic [NDEV-1:0]     mask;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } uvp_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [NDEV-1:0]     sel;
      logic                gate_n;
      logic                ref_sel;
      logic                vpp_high;
      logic [DATA_W-1:0]   dout;
      logic                doe;
   } uvp_pins_t;

   typedef struct packed {
      uvp_state_t          state;
      logic [CNT_W-1:0]    cnt;
      logic [DEV_W-1:0]    dev;
      logic [NDEV-1:0]     mask;
      logic [DATA_W-1:0]   data;
      logic                ok;
      uvp_pins_t           pins;
      logic                rdy;
      logic                rsp_valid;
      logic [DATA_W-1:0]   rsp_data;
      logic                rsp_ok;
   } uvp_regs_t;
endpackage

//--- hw/uvp_ctrl.sv
`timescale 1ns/1ps
module uvp_ctrl
   import uvp_pkg::*;
#(
   parameter int PULSE_CYC_P = PULSE_CYC
) (
   // Clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_n_i,
   // Command side
   input  wire logic               cmd_valid_i,
   input  wire uvp_cmd_t           cmd_i,
   output logic                    cmd_ready_o,
   // Response side
   output logic                    rsp_valid_o,
   output logic [DATA_W-1:0]       rsp_data_o,
   output logic                    rsp_ok_o,
   // Memory device pins
   output uvp_pins_t               ep_o,
   input  wire logic [DATA_W-1:0]  ep_data_i
);
   uvp_regs_t q;                    // All state
   uvp_regs_t d;                    // Next state
   logic [NDEV-1:0] dev_bit;        // One-hot of device under verify
   logic            take;           // Command accepted this cycle

   assign dev_bit = NDEV'(1) << q.dev;
   assign take    = cmd_valid_i && q.rdy;

   // Next-state logic; one counter times every phase
   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      d.pins.ref_sel = REF_LEVEL;
      if (q.cnt != '0) begin
         d.cnt = q.cnt - CNT_W'(1);
      end
      unique case (q.state)
         S_IDLE: begin
            // Idle: all devices deselected, gate high, supply at 5V
            d.pins.sel      = '1;
            d.pins.gate_n   = 1'b1;
            d.pins.vpp_high = 1'b0;
            d.pins.doe      = 1'b0;
            if (take) begin
               d.rdy       = 1'b0;
               d.mask      = cmd_i.mask;
               d.data      = cmd_i.data;
               d.pins.addr = cmd_i.addr;
               if (cmd_i.op == OP_READ) begin
                  // Lowest requested device only, gate as read strobe
                  d.pins.sel    = ~(cmd_i.mask & (~cmd_i.mask + NDEV'(1)));
                  d.pins.gate_n = 1'b0;
                  d.cnt         = CNT_W'(ACC_CYC - 1);
                  d.state       = S_RD_ACC;
               end else begin
                  // Raise supply while every select is held low: inhibit
                  d.pins.sel      = '0;
                  d.pins.vpp_high = 1'b1;
                  d.cnt           = CNT_W'(VPP_CYC - 1);
                  d.state         = S_PG_VPP;
               end
            end
         end
         S_RD_ACC: begin
            // Sample once the full access time has elapsed
            if (q.cnt == '0) begin
               d.rsp_data    = ep_data_i;
               d.rsp_ok      = 1'b1;
               d.pins.sel    = '1;
               d.pins.gate_n = 1'b1;
               d.cnt         = CNT_W'(FLOAT_CYC - 1);
               d.state       = S_RD_FLOAT;
            end
         end
         S_RD_FLOAT: begin
            // Let the device release the bus before the next command
            if (q.cnt == '0) begin
               d.rsp_valid = 1'b1;
               d.rdy       = 1'b1;
               d.state     = S_IDLE;
            end
         end
         S_PG_VPP: begin
            // Gate high, pulse lines low; data driven once the supply has settled
            if (q.cnt == '0) begin
               d.pins.dout = q.data;
               d.pins.doe  = 1'b1;
               d.cnt       = CNT_W'(SETUP_CYC - 1);
               d.state     = S_PG_SETUP;
            end
         end
         S_PG_SETUP: begin
            // Address and data settled: start the single pulse
            if (q.cnt == '0) begin
               d.pins.sel = q.mask;
               d.cnt      = CNT_W'(PULSE_CYC_P - 1);
               d.state    = S_PG_PULSE;
            end
         end
         S_PG_PULSE: begin
            // Steady high level for the whole width, no chopping
            if (q.cnt == '0) begin
               d.pins.sel = '0;
               d.cnt      = CNT_W'(SETUP_CYC - 1);
               d.state    = S_PG_HOLD;
            end
         end
         S_PG_HOLD: begin
            // Data held past the pulse, then released for verify
            if (q.cnt == '0) begin
               d.pins.doe = 1'b0;
               d.dev      = '0;
               d.ok       = 1'b1;
               d.cnt      = CNT_W'(FLOAT_CYC - 1);
               d.state    = S_PV_FLOAT;
            end
         end
         S_PV_FLOAT: begin
            // Bus idle gap, then select the next device to verify
            if (q.cnt == '0) begin
               d.pins.sel    = ~(dev_bit & q.mask);
               d.pins.gate_n = 1'b0;
               d.cnt         = CNT_W'(ACC_CYC - 1);
               d.state       = S_PV_ACC;
            end
         end
         S_PV_ACC: begin
            // A zero in the data must read back as zero
            if (q.cnt == '0) begin
               if (q.mask[q.dev] && ((ep_data_i & ~q.data) != '0)) begin
                  d.ok = 1'b0;
               end
               d.pins.sel    = '0;
               d.pins.gate_n = 1'b1;
               d.cnt         = CNT_W'(FLOAT_CYC - 1);
               if (q.dev == DEV_W'(NDEV - 1)) begin
                  d.pins.vpp_high = 1'b0;
                  d.cnt           = CNT_W'(VPP_CYC - 1);
                  d.state         = S_PG_VPPOFF;
               end else begin
                  d.dev   = q.dev + DEV_W'(1);
                  d.state = S_PV_FLOAT;
               end
            end
         end
         S_PG_VPPOFF: begin
            // Supply back to 5V before selects may go high again
            if (q.cnt == '0) begin
               d.pins.sel  = '1;
               d.rsp_data  = q.data;
               d.rsp_ok    = q.ok;
               d.rsp_valid = 1'b1;
               d.rdy       = 1'b1;
               d.state     = S_IDLE;
            end
         end
         default: begin
            // Unused codes fall back to idle
            d.state = S_IDLE;
         end
      endcase
   end

   // State register, synchronous reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         q                 <= '0;
         q.state           <= S_IDLE;
         q.pins.sel        <= '1;
         q.pins.gate_n     <= 1'b1;
         q.pins.ref_sel    <= REF_LEVEL;
         q.rdy             <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready_o = q.rdy;
   assign rsp_valid_o = q.rsp_valid;
   assign rsp_data_o  = q.rsp_data;
   assign rsp_ok_o    = q.rsp_ok;
   assign ep_o        = q.pins;

   // Helper: a program pulse is on and how long it has lasted
   logic             pulse_on;
   logic [CNT_W-1:0] plen_q;
   assign pulse_on = ep_o.vpp_high && ep_o.gate_n && (ep_o.sel != '0);
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         plen_q <= '0;
      end else if (pulse_on) begin
         plen_q <= plen_q + CNT_W'(1);
      end else begin
         plen_q <= '0;
      end
   end

   sequence s_pulse_end;
      $fell(pulse_on);
   endsequence

   property p_pulse_width;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_pulse_end |-> plen_q == CNT_W'(PULSE_CYC_P);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("Pulse width wrong");

   property p_pulse_max;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      plen_q <= CNT_W'(PULSE_MAX_CYC);
   endproperty
   a_pulse_max: assert property (p_pulse_max) else $error("Pulse too long");

   property p_pulse_steady;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      pulse_on && $past(pulse_on) |-> $stable(ep_o.sel) && $stable(ep_o.dout);
   endproperty
   a_pulse_steady: assert property (p_pulse_steady) else $error("Pulse not steady");

   property p_one_pulse;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_pulse_end |-> (!pulse_on)[*8];
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("Extra pulse");

   property p_prog_mode;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      pulse_on |-> ep_o.doe && ep_o.sel == q.mask;
   endproperty
   a_prog_mode: assert property (p_prog_mode) else $error("Pulse without data");

   property p_verify_follows;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_pulse_end |-> ##[1:60] (!ep_o.gate_n && ep_o.vpp_high && !ep_o.doe);
   endproperty
   a_verify_follows: assert property (p_verify_follows) else $error("No verify");

   property p_vpp_low;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (q.state == S_IDLE || q.state == S_RD_ACC || q.state == S_RD_FLOAT) |-> !ep_o.vpp_high;
   endproperty
   a_vpp_low: assert property (p_vpp_low) else $error("Supply high in read");

   property p_ref_level;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ##1 ep_o.ref_sel == REF_LEVEL;
   endproperty
   a_ref_level: assert property (p_ref_level) else $error("Reference level wrong");

   property p_read_decode;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !ep_o.gate_n && !ep_o.vpp_high |-> $onehot0(~ep_o.sel) && !ep_o.doe;
   endproperty
   a_read_decode: assert property (p_read_decode) else $error("Bus contention");

   // Read answer time seen from the command side, counted from the taking edge
   localparam int RD_LAT = ACC_CYC + FLOAT_CYC + 1;

   // A read command accepted this cycle
   sequence s_read_take;
      take && (cmd_i.op == OP_READ);
   endsequence

   // Gate strobe just went low, for a read or a verify
   sequence s_gate_fall;
      $fell(ep_o.gate_n);
   endsequence

   property p_read_latency;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_read_take |-> ##RD_LAT rsp_valid_o;
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("Read answer late");

   // The part needs the full access window before its data is sampled
   property p_gate_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_gate_fall |-> (!ep_o.gate_n)[*8];
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("Gate released early");

   // Supply may only rise while every part is held in inhibit
   property p_supply_rise;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(ep_o.vpp_high) |-> (ep_o.sel == '0) && !ep_o.doe;
   endproperty
   a_supply_rise: assert property (p_supply_rise) else $error("Supply raised while selected");

   // Selects stay low while the supply falls back to 5V
   property p_supply_fall;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(ep_o.vpp_high) |-> (ep_o.sel == '0)[*8];
   endproperty
   a_supply_fall: assert property (p_supply_fall) else $error("Select raised too soon");

   // Host data only ever meets the pins in program mode
   property p_data_needs_supply;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ep_o.doe |-> ep_o.vpp_high;
   endproperty
   a_data_needs_supply: assert property (p_data_needs_supply) else $error("Data at read supply");

   // Parts outside the mask never see a high select at program supply while the gate is high
   property p_inhibit_others;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ep_o.vpp_high && ep_o.gate_n |-> (ep_o.sel & ~q.mask) == '0;
   endproperty
   a_inhibit_others: assert property (p_inhibit_others) else $error("Unselected part pulsed");

   // One command, one location: no second command while busy
   property p_ready_drop;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take |=> !cmd_ready_o;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("Busy but still ready");
endmodule

//--- tb/uvp_dev_model.sv
`timescale 1ns/1ps
module uvp_dev_model
   import uvp_pkg::*;
(
   // Pins from the controller
   input  wire uvp_pins_t     pins_i,
   // Data back to the controller
   output logic [DATA_W-1:0]  data_o
);
   logic [DATA_W-1:0] mem [NDEV][1024]; // Four parts, one byte per location
   logic [DATA_W-1:0] last_q;           // Last value driven; inverted when floating
   logic              act;              // One part selected with its gate low
   logic              valid_w;          // Gate has been low long enough
   int                who;              // Index of the part on the bus

   // Every part starts erased
   initial begin
      foreach (mem[i, j]) mem[i][j] = ERASED;
      last_q = '0;
   end

   // Mode comes from present pin levels only; a deselected part floats
   always_comb begin
      who = -1;
      for (int i = 0; i < NDEV; i++) begin
         if (!pins_i.sel[i]) who = i;
      end
      act = (who >= 0) && !pins_i.gate_n && (pins_i.ref_sel == REF_LEVEL);
   end

   // Inertial delay: a short gate pulse never shows data
   assign #120 valid_w = act;

   // Floating bus shows the inverse of its last value, never a stale copy
   always_comb data_o = (act && valid_w) ? mem[who][pins_i.addr] : ~last_q;
   always @(data_o) begin
      if (act && valid_w) last_q = data_o;
   end

   // Write at the end of the high pulse; a part held low is inhibited
   for (genvar g = 0; g < NDEV; g++) begin : g_dev
      always @(negedge pins_i.sel[g]) begin
         if (pins_i.vpp_high && pins_i.gate_n && pins_i.doe) begin
            // Last part has one cell whose low bit will not program,
            // so that a failed verify can be seen by the controller
            mem[g][pins_i.addr] &= pins_i.dout |
               (((g == NDEV - 1) && (pins_i.addr == '1)) ? 8'h01 : 8'h00);
         end
      end
   end
endmodule

//--- tb/uvp_ctrl_test.sv
`timescale 1ns/1ps
module uvp_ctrl_test
   import uvp_pkg::*;
;
   logic              core_clk_i;
   logic              rst_n_i;
   logic              cmd_valid_i;
   uvp_cmd_t          cmd_i;
   logic              cmd_ready_o;
   logic              rsp_valid_o;
   logic [DATA_W-1:0] rsp_data_o;
   logic              rsp_ok_o;
   uvp_pins_t         ep_o;
   logic [DATA_W-1:0] ep_data_i;
   int                err_count;
   int                compares;
   logic [DATA_W-1:0] rd;
   logic              ok;
   int                lat;

   // Short pulse keeps the run brief; the pulse rule only scales with it
   uvp_ctrl #(.PULSE_CYC_P(20)) dut_u (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .cmd_valid_i (cmd_valid_i),
      .cmd_i       (cmd_i),
      .cmd_ready_o (cmd_ready_o),
      .rsp_valid_o (rsp_valid_o),
      .rsp_data_o  (rsp_data_o),
      .rsp_ok_o    (rsp_ok_o),
      .ep_o        (ep_o),
      .ep_data_i   (ep_data_i)
   );

   uvp_dev_model model_u (
      .pins_i (ep_o),
      .data_o (ep_data_i)
   );

   // Clock at 20 MHz
   initial core_clk_i = 1'b0;
   always #25 core_clk_i = ~core_clk_i;

   // Compare and report
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   // One command; latency counted in cycles after the taking edge
   task automatic cmd(input uvp_op_t op, input logic [3:0] m, input logic [9:0] a,
                      input logic [7:0] d);
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_i       <= '{op: op, mask: m, addr: a, data: d};
      @(posedge core_clk_i);
      while (cmd_ready_o !== 1'b1) @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
      lat = 0;
      while (lat < 3000) begin
         @(negedge core_clk_i);
         lat++;
         if (rsp_valid_o === 1'b1) break;
      end
      // No answer within the limit ends the run as a failure
      if (rsp_valid_o !== 1'b1) begin
         $display("BAD rsp_valid expected 1 seen %b", rsp_valid_o);
         err_count++;
         results();
      end
      rd = rsp_data_o;
      ok = rsp_ok_o;
   endtask

   // Pins idle after reset: standby, low supply, no data driven
   task automatic t_reset();
      chk("sel", 8'h0f, {4'h0, ep_o.sel});
      chk("gate_n", 8'h01, {7'h0, ep_o.gate_n});
      chk("vpp_high", 8'h00, {7'h0, ep_o.vpp_high});
      chk("doe", 8'h00, {7'h0, ep_o.doe});
      chk("ready", 8'h01, {7'h0, cmd_ready_o});
   endtask

   // Erased byte reads as all ones with the fixed latency
   task automatic t_read_erased();
      cmd(OP_READ, 4'h1, 10'h3ff, 8'h00);
      chk("rd erased", ERASED, rd);
      chk("rd latency", 8'(ACC_CYC + FLOAT_CYC + 1), lat[7:0]);
      chk("rd ok", 8'h01, {7'h0, ok});
   endtask

   // One part written; its neighbour, held low, keeps its ones
   task automatic t_prog_one();
      cmd(OP_PROG, 4'h2, 10'h005, 8'ha5);
      chk("pg ok", 8'h01, {7'h0, ok});
      chk("pg data", 8'ha5, rd);
      cmd(OP_READ, 4'h2, 10'h005, 8'h00);
      chk("rd dev1", 8'ha5, rd);
      cmd(OP_READ, 4'h1, 10'h005, 8'h00);
      chk("rd dev0", 8'hff, rd);
   endtask

   // Second write can only clear more bits
   task automatic t_prog_and();
      cmd(OP_PROG, 4'h2, 10'h005, 8'h5a);
      chk("pg2 ok", 8'h01, {7'h0, ok});
      cmd(OP_READ, 4'h2, 10'h005, 8'h00);
      chk("rd and", 8'h00, rd);
   endtask

   // All parts written by one shared pulse
   task automatic t_prog_all();
      cmd(OP_PROG, 4'hf, 10'h000, 8'h3c);
      chk("pg all ok", 8'h01, {7'h0, ok});
      for (int i = 0; i < NDEV; i++) begin
         cmd(OP_READ, 4'(1 << i), 10'h000, 8'h00);
         chk("rd all", 8'h3c, rd);
      end
   endtask

   // A cell that will not program must be reported by the verify pass
   task automatic t_prog_fail();
      cmd(OP_PROG, 4'h8, 10'h3ff, 8'h00);
      chk("pg fail ok", 8'h00, {7'h0, ok});
      chk("pg fail data", 8'h00, rd);
      cmd(OP_READ, 4'h8, 10'h3ff, 8'h00);
      chk("rd stuck", 8'h01, rd);
   endtask

   // Level pins watched every cycle out of reset
   always @(negedge core_clk_i) begin
      if (rst_n_i === 1'b1) begin
         chk("ref_sel", {7'h0, REF_LEVEL}, {7'h0, ep_o.ref_sel});
         if (ep_o.doe === 1'b1) chk("doe vpp", 8'h01, {7'h0, ep_o.vpp_high});
      end
   end

   // Verdict, the single end of the run
   task automatic results();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog; the whole sequence needs about 1020 cycles, the limit is 10000
   initial begin
      #500000;
      err_count++;
      results();
   end

   // Main sequence
   initial begin
      err_count   = 0;
      compares    = 0;
      rst_n_i     = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i       = '0;
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(negedge core_clk_i);
      t_reset();
      t_read_erased();
      t_prog_one();
      t_prog_and();
      t_prog_all();
      t_prog_fail();
      results();
   end
endmodule
